/* igc_cfg.svh */
/*
 Constants for the I2C slave acknowledge and general call block.
 Assumes inclusion by the package and the design modules only.
*/
`ifndef IGC_CFG_SVH
`define IGC_CFG_SVH

`define IGC_GC_ADDR 8'h00
`define IGC_GC_CMD_RESET 8'h06
`define IGC_GC_CMD_WRITE 8'h04
`define IGC_ID_GC_NONE 2'h0
`define IGC_ID_GC_RESET 2'h1
`define IGC_ID_GC_WRITE 2'h2
`define IGC_ID_GC_HW 2'h3
`define IGC_SLAVE_ADDR_RST 7'h00

`endif

/* igc_pkg.sv */
/*
 Types shared by the I2C slave acknowledge and general call block.
 Assumes igc_cfg.svh is on the include path.
*/
`include "igc_cfg.svh"

package igc_pkg;

   // ==========================================================
   // Control bits from software
   typedef struct packed {
      logic sw_nack_next_byte;
      logic reserved_bit6;
      logic early_tx_request_irq_sel;
      logic gen_call_status_clear;
      logic hw_gen_call_enable;
      logic gen_call_enable;
      logic slave_enable;
   } igc_ctrl_t;

   // ==========================================================
   // General call status as seen by software
   typedef struct packed {
      logic gen_call_flag;
      logic [1:0] gen_call_id;
      logic hw_gen_call;
   } igc_gc_stat_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_AACK = 6'h04,
      ST_WDATA = 6'h08,
      ST_DACK = 6'h10,
      ST_READ = 6'h20
   } igc_state_t;

endpackage : igc_pkg

/* igc_sync.sv */
/*
 Two-flop synchroniser for a pin level.
 Assumes the input is asynchronous to clk_in.
*/
`timescale 1ns/1ps

module igc_sync (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic d_in,
   output logic q_out
);

   logic meta_reg;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= 1'b1;
         q_out <= 1'b1;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end

endmodule : igc_sync

/* igc_slave.sv */
/*
 I2C slave bit engine with acknowledge control, transmit request timing
 and general call recognition (software and hardware general call).
 Assumes open-drain bus wires resolved outside; control bits are ports.
*/
`timescale 1ns/1ps
`include "igc_cfg.svh"

// Function
// - Software nack bit set: next data byte gets not-acknowledge instead of acknowledge.
// - Nack bit clear: hardware decides acknowledge for each received byte.
// - Early select set: transmit request just after clock rising edge in read bit.
// - Early select clear: transmit request just after clock falling edge in read bit.
// - Clear bit written one clears general call flag and ID.
// - Both enables set: byte after address 0x00 compared to alternate address.
// - General call enable: ack 0x00; data 0x06 resets, 0x04 sets status.
module igc_slave (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire igc_pkg::igc_ctrl_t ctrl_in,
   input wire logic [6:0] slave_addr_in,
   input wire logic [7:0] alternate_address_reg_in,
   input wire logic [7:0] tx_data_in,
   input wire logic serial_clock_line_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic tx_request_out,
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic gc_reset_out,
   output igc_pkg::igc_gc_stat_t slave_status_reg_out
);
   import igc_pkg::*;

   // ==========================================================
   // Pin synchronisation and edge detection
   logic scl_s, sda_s, scl_d_reg, sda_d_reg;
   logic scl_rise, scl_fall, start_det, stop_det;

   igc_sync u_scl (.clk_in(clk_in), .rst_in(rst_in), .d_in(serial_clock_line_in), .q_out(scl_s));
   igc_sync u_sda (.clk_in(clk_in), .rst_in(rst_in), .d_in(sda_in), .q_out(sda_s));

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ==========================================================
   // Bit engine
   igc_state_t state_reg;
   logic [7:0] shift_reg;
   logic [2:0] bit_cnt_reg;
   logic is_gc_reg, gc_data_reg, nack_pend_reg, master_nack_reg, in_slot_reg;
   logic [7:0] rx_byte;
   logic ack_this;

   assign rx_byte = {shift_reg[6:0], sda_s};

   function automatic logic addr_hit(input logic [7:0] b, input logic [6:0] a, input logic gce);
      addr_hit = (b[7:1] == a) || (gce && b == `IGC_GC_ADDR);
   endfunction : addr_hit

   // Hardware ack decision; software nack overrides it
   always_comb begin
      ack_this = ~nack_pend_reg;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         is_gc_reg <= 1'b0;
         gc_data_reg <= 1'b0;
         master_nack_reg <= 1'b0;
      end else if (!ctrl_in.slave_enable || stop_det || gc_reset_out) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 3'h0;
      end else if (start_det) begin
         state_reg <= ST_ADDR;
         bit_cnt_reg <= 3'h0;
         is_gc_reg <= 1'b0;
         gc_data_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_reg <= rx_byte;
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7) begin
                     if (addr_hit(rx_byte, slave_addr_in, ctrl_in.gen_call_enable)) begin
                        state_reg <= ST_AACK;
                        is_gc_reg <= (rx_byte == `IGC_GC_ADDR);
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall && in_slot_reg) begin
                  state_reg <= shift_reg[0] ? ST_READ : ST_WDATA;
                  shift_reg <= tx_data_in;
               end
            end
            ST_WDATA: begin
               if (scl_rise) begin
                  shift_reg <= rx_byte;
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7) begin
                     state_reg <= ST_DACK;
                  end
               end
            end
            ST_DACK: begin
               if (scl_fall && in_slot_reg) begin
                  state_reg <= ack_this ? ST_WDATA : ST_IDLE;
                  gc_data_reg <= is_gc_reg;
               end
            end
            ST_READ: begin
               // Master acknowledge bit is sampled, not counted
               if (scl_rise && in_slot_reg) begin
                  master_nack_reg <= sda_s;
               end else if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
               end
               if (scl_fall && in_slot_reg) begin
                  if (master_nack_reg) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     shift_reg <= tx_data_in;
                  end
               end else if (scl_fall && bit_cnt_reg != 3'h0) begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Acknowledge bit tracking: opened by one clock fall, closed by the next
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         in_slot_reg <= 1'b0;
      end else if (state_reg == ST_IDLE || state_reg == ST_ADDR || state_reg == ST_WDATA ||
            start_det || stop_det) begin
         in_slot_reg <= 1'b0;
      end else if (scl_fall) begin
         in_slot_reg <= ~in_slot_reg & (state_reg != ST_READ || bit_cnt_reg == 3'h0);
      end
   end

   // ==========================================================
   // Software nack is consumed by the next data acknowledge slot
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         nack_pend_reg <= 1'b0;
      end else if (ctrl_in.sw_nack_next_byte) begin
         nack_pend_reg <= 1'b1;
      end else if (state_reg == ST_DACK && scl_fall && in_slot_reg) begin
         nack_pend_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Data line drive
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sda_out <= 1'b1;
         sda_oe_out <= 1'b0;
      end else if (scl_fall) begin
         sda_out <= 1'b0;
         if (state_reg == ST_AACK && !in_slot_reg) begin
            sda_oe_out <= 1'b1;
         end else if (state_reg == ST_DACK && !in_slot_reg) begin
            sda_oe_out <= ack_this;
         end else if (state_reg == ST_AACK && shift_reg[0]) begin
            sda_oe_out <= ~tx_data_in[7];
         end else if (state_reg == ST_READ && in_slot_reg && !master_nack_reg) begin
            sda_oe_out <= ~tx_data_in[7];
         end else if (state_reg == ST_READ && !in_slot_reg && bit_cnt_reg != 3'h0) begin
            sda_oe_out <= ~shift_reg[6];
         end else begin
            sda_oe_out <= 1'b0;
         end
      end else if (state_reg == ST_IDLE || start_det || stop_det) begin
         sda_oe_out <= 1'b0;
      end
   end

   // ==========================================================
   // Transmit request during the read bit of the address byte
   logic read_bit_slot;
   assign read_bit_slot = (state_reg == ST_ADDR) && (bit_cnt_reg == 3'h7) && sda_s;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_request_out <= 1'b0;
      end else if (ctrl_in.early_tx_request_irq_sel) begin
         tx_request_out <= read_bit_slot && scl_rise &&
            addr_hit(rx_byte, slave_addr_in, ctrl_in.gen_call_enable);
      end else begin
         tx_request_out <= state_reg == ST_AACK && shift_reg[0] && scl_fall && !in_slot_reg;
      end
   end

   // ==========================================================
   // Received byte strobe
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_valid_out <= 1'b0;
         rx_data_out <= 8'h00;
      end else begin
         rx_valid_out <= (state_reg == ST_DACK) && scl_fall && in_slot_reg && sda_oe_out;
         if ((state_reg == ST_DACK) && scl_fall && in_slot_reg && sda_oe_out) begin
            rx_data_out <= shift_reg;
         end
      end
   end

   // ==========================================================
   // General call status; a new event wins over a clear
   logic gc_byte_done;
   assign gc_byte_done = (state_reg == ST_WDATA) && scl_rise && bit_cnt_reg == 3'h7 && is_gc_reg && !gc_data_reg;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         slave_status_reg_out <= '0;
         gc_reset_out <= 1'b0;
      end else begin
         gc_reset_out <= gc_byte_done && rx_byte == `IGC_GC_CMD_RESET;
         if (gc_byte_done && ctrl_in.hw_gen_call_enable && ctrl_in.gen_call_enable &&
               rx_byte == alternate_address_reg_in) begin
            slave_status_reg_out <= '{1'b1, `IGC_ID_GC_HW, 1'b1};
         end else if (gc_byte_done && rx_byte == `IGC_GC_CMD_RESET) begin
            slave_status_reg_out <= '{1'b1, `IGC_ID_GC_RESET, 1'b0};
         end else if (gc_byte_done && rx_byte == `IGC_GC_CMD_WRITE) begin
            slave_status_reg_out <= '{1'b1, `IGC_ID_GC_WRITE, 1'b0};
         end else if (ctrl_in.gen_call_status_clear) begin
            slave_status_reg_out <= '0;
         end
      end
   end

endmodule : igc_slave

/* igc_slave_sva.sv */
/*
 Port checker for igc_slave, bound to every instance.
 Assumes one clock domain and the bus pins as seen at the slave.
*/
`timescale 1ns/1ps
module igc_slave_sva
   import igc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire igc_pkg::igc_ctrl_t ctrl_in,
   input wire logic serial_clock_line_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic tx_request_out,
   input wire logic rx_valid_out,
   input wire logic gc_reset_out,
   input wire igc_pkg::igc_gc_stat_t slave_status_reg_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   // ==========================================================
   // Data line
   AST_SDA_LOW: assert property (sda_oe_out |-> !sda_out) else $error("sda driven high");
   AST_SDA_SCL_LOW: assert property ($changed(sda_oe_out) |-> !serial_clock_line_in)
      else $error("sda moved while clock high");
   // ==========================================================
   // Transmit request timing
   AST_TXR_EARLY: assert property (tx_request_out && ctrl_in.early_tx_request_irq_sel |-> serial_clock_line_in)
      else $error("early request outside clock high");
   AST_TXR_LATE: assert property (tx_request_out && !ctrl_in.early_tx_request_irq_sel |-> !serial_clock_line_in)
      else $error("late request outside clock low");
   // ==========================================================
   // General call status
   AST_GC_CLEAR: assert property (ctrl_in.gen_call_status_clear && !rx_valid_out && !gc_reset_out
      |-> ##[1:2] slave_status_reg_out == 4'h0) else $error("status not cleared");
   AST_HW_ID: assert property (slave_status_reg_out.hw_gen_call |-> slave_status_reg_out[3:1] == 3'h7)
      else $error("hardware call id wrong");
   AST_HW_EN: assert property ($rose(slave_status_reg_out.hw_gen_call)
      |-> ctrl_in.hw_gen_call_enable && ctrl_in.gen_call_enable) else $error("hardware call while disabled");
   AST_GC_EN: assert property ($rose(slave_status_reg_out.gen_call_flag) |-> ctrl_in.gen_call_enable)
      else $error("general call while disabled");
   AST_GC_RESET: assert property (gc_reset_out |=> !gc_reset_out ##[0:2] slave_status_reg_out[2:1] == 2'h1)
      else $error("reset call status wrong");
   cover property ($rose(slave_status_reg_out.hw_gen_call));
   cover property (gc_reset_out);
   cover property (tx_request_out && ctrl_in.early_tx_request_irq_sel);
endmodule : igc_slave_sva

bind igc_slave igc_slave_sva chk (.clk_in(clk_in), .rst_in(rst_in), .ctrl_in(ctrl_in),
   .serial_clock_line_in(serial_clock_line_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
   .tx_request_out(tx_request_out), .rx_valid_out(rx_valid_out), .gc_reset_out(gc_reset_out),
   .slave_status_reg_out(slave_status_reg_out));

/* igc_bus_master.sv */
/*
 Behavioural I2C bus master that drives the clock and pulls the data line.
 Assumes a pull-up on the data line resolved by the bench.
*/
`timescale 1ns/1ps
module igc_bus_master (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   int half = 20;
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask : wt
   task automatic start();
      sda_oe_out <= 1'b1;
      wt(half);
      scl_out <= 1'b0;
   endtask : start
   // Sample at the end of the high phase, just before the clock falls
   task automatic bit_io(input logic b, output logic r);
      wt(2);
      sda_oe_out <= !b;
      wt(half);
      scl_out <= 1'b1;
      wt(half);
      r = sda_in;
      scl_out <= 1'b0;
   endtask : bit_io
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : wbyte
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, r);
   endtask : rbyte
   task automatic stop();
      wt(2);
      sda_oe_out <= 1'b1;
      wt(half);
      scl_out <= 1'b1;
      wt(half);
      sda_oe_out <= 1'b0;
      wt(half);
   endtask : stop
endmodule : igc_bus_master

/* tb.sv */
/*
 Self-checking bench for igc_slave.
 Assumes igc_bus_master as the far side of the bus.
*/
`timescale 1ns/1ps
module tb;
   import igc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   igc_ctrl_t ctrl = 7'h01;
   logic [7:0] alt = 8'h55;
   logic scl, m_oe, s_oe, s_do, txr, rxv, gcr, a;
   logic [7:0] rxd, d;
   igc_gc_stat_t st;
   int n_errors = 0;
   int check_count = 0;
   int n_txr = 0;
   int n_gcr = 0;
   wire sda = !(m_oe || s_oe);
   igc_bus_master m (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
   igc_slave DUT (.clk_in(clk_in), .rst_in(rst_in), .ctrl_in(ctrl), .slave_addr_in(7'h2A),
      .alternate_address_reg_in(alt), .tx_data_in(8'h3C), .serial_clock_line_in(scl), .sda_in(sda),
      .sda_out(s_do), .sda_oe_out(s_oe), .tx_request_out(txr), .rx_valid_out(rxv), .rx_data_out(rxd),
      .gc_reset_out(gcr), .slave_status_reg_out(st));
   initial forever #10 clk_in = !clk_in;
   always @(posedge clk_in) begin
      n_txr += int'(txr === 1'b1);
      n_gcr += int'(gcr === 1'b1);
   end
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic summarize();
      if (n_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   // ==========================================================
   // Scenarios
   task automatic t_write();
      m.start();
      m.wbyte(8'h54, a);
      check("addr ack", a, 1'b1);
      m.wbyte(8'hA5, a);
      check("data ack", a, 1'b1);
      m.wt(4);
      check("rx data", rxd, 8'hA5);
      @(posedge clk_in) ctrl.sw_nack_next_byte <= 1'b1;
      @(posedge clk_in) ctrl.sw_nack_next_byte <= 1'b0;
      m.wbyte(8'h5A, a);
      check("nack byte", a, 1'b0);
      m.stop();
      m.start();
      m.wbyte(8'h20, a);
      check("other addr", a, 1'b0);
      m.stop();
   endtask : t_write
   task automatic t_read(input logic early);
      @(posedge clk_in) ctrl.early_tx_request_irq_sel <= early;
      m.half = early ? 20 : 40;
      n_txr = 0;
      m.start();
      m.wbyte(8'h55, a);
      check("read addr ack", a, 1'b1);
      check("tx request", 8'(n_txr), 8'h01);
      m.rbyte(1'b1, d);
      check("read data", d, 8'h3C);
      m.stop();
   endtask : t_read
   task automatic t_gc(input logic gce, input logic hwe, input logic [7:0] b, input logic [3:0] exp);
      @(posedge clk_in) ctrl.gen_call_status_clear <= 1'b1;
      @(posedge clk_in) ctrl.gen_call_status_clear <= 1'b0;
      ctrl.gen_call_enable <= gce;
      ctrl.hw_gen_call_enable <= hwe;
      alt <= 8'h55;
      m.wt(3);
      check("cleared", st, 8'h00);
      n_gcr = 0;
      m.start();
      m.wbyte(8'h00, a);
      check("gc ack", a, gce);
      if (a === 1'b1) m.wbyte(b, a);
      m.stop();
      check("gc status", st, exp);
      check("gc reset", n_gcr != 0, b == 8'h06 && gce);
   endtask : t_gc
   initial begin
      repeat (60000) @(posedge clk_in);
      n_errors++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      m.wt(4);
      t_write();
      t_read(1'b1);
      t_read(1'b0);
      t_gc(1'b1, 1'b0, 8'h04, 4'hC);
      t_gc(1'b1, 1'b0, 8'h06, 4'hA);
      t_gc(1'b1, 1'b1, 8'h55, 4'hF);
      t_gc(1'b1, 1'b1, 8'h04, 4'hC);
      t_gc(1'b0, 1'b0, 8'h04, 4'h0);
      summarize();
   end
endmodule : tb
